/* design/pfs_pkg.sv */
package pfs_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] OFF_PWR = 4'h0;
	localparam logic [3:0] OFF_CLK = 4'h1;
	localparam logic [3:0] OFF_WAKE = 4'h2;
	localparam logic [3:0] OFF_STAT = 4'h3;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int PWR_MON_OFF_BIT = 0;
	localparam int PWR_LVL_LSB = 1;
	localparam int PWR_INTV_LSB = 3;
	localparam int PWR_STOP_BIT = 5;
	localparam int CLK_IE_BIT = 0;
	localparam int CLK_FLAG_BIT = 1;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic MON_OFF_RST = 1'b1;
	localparam logic [1:0] LVL_RST = 2'h0;
	localparam logic [1:0] INTV_RST = 2'h0;
	localparam logic [15:0] WAKE_RST = 16'h0000;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int WARN_QUALIFY_NS = 10000;
	localparam int WARN_QUALIFY_CYC = (WARN_QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int XTAL_WARMUP_NS = 200000;
	localparam int XTAL_WARMUP_CYC = (XTAL_WARMUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT_RELEASE_CYC = 4;
	localparam int SAMPLE_TICKS = 2;
	localparam int CONFIRM_TICKS = 1;
	localparam int INTV_BASE_EXP = 10;

	// ****************************************
	// States
	// ****************************************
	typedef enum logic [3:0] {
		PFS_POR_HOLD,
		PFS_WARMUP,
		PFS_RUN,
		PFS_STOP,
		PFS_WAKE,
		PFS_PF_SLEEP,
		PFS_PF_SAMPLE,
		PFS_PF_CONFIRM,
		PFS_EXT_RST
	} pfs_state_e;

endpackage : pfs_pkg

/* design/pfs_supervisor.sv */
`timescale 1ns/1ns

module pfs_supervisor (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [pfs_pkg::ADDR_W-1:0] addr,
	input wire logic [pfs_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [pfs_pkg::DATA_W-1:0] rdata,
	input wire logic bus_above_3v0,
	input wire logic bus_above_batt,
	input wire logic batt_present,
	input wire logic below_warn,
	input wire logic below_reset,
	input wire logic below_por,
	input wire logic ext_irq,
	input wire logic ext_reset_n,
	input wire logic wdt_reset,
	input wire logic ring_osc,
	output logic supply_from_bus,
	output logic [1:0] warn_level_sel,
	output logic monitor_en,
	output logic regulator_en,
	output logic xtal_en,
	output logic cpu_clk_en,
	output logic cpu_reset_n,
	output logic start_rom,
	output logic stop_wake,
	output logic warn_irq
);

	// ****************************************
	// Declarations
	// ****************************************
	pfs_pkg::pfs_state_e state_q;
	pfs_pkg::pfs_state_e state_d;
	logic ring_s1_q;
	logic ring_s2_q;
	logic ring_s3_q;
	logic ring_tick;
	logic [15:0] cyc_cnt_q;
	logic [15:0] ring_cnt_q;
	logic [15:0] warn_cnt_q;
	logic mon_off_q;
	logic [1:0] lvl_q;
	logic [1:0] intv_q;
	logic [15:0] wake_q;
	logic ie_q;
	logic flag_q;
	logic sup_bus_q;
	logic mon_on;
	logic suppress;
	logic pf_rst_ev;
	logic warn_cond;
	logic warn_set;
	logic wake_exit_warn;
	logic stop_req;
	logic ext_rst;
	logic warm_done;
	logic timer_exp;
	logic wake_ev;
	logic period_done;
	logic flag_clr;

	function automatic logic hit(input logic [pfs_pkg::ADDR_W-1:0] a, input logic [pfs_pkg::ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic [15:0] period_ticks(input logic [1:0] intv);
		if (intv == 2'h0) begin
			period_ticks = 16'h0000;
		end else begin
			period_ticks = 16'h0001 << (pfs_pkg::INTV_BASE_EXP + int'(intv));
		end
	endfunction : period_ticks

	// ****************************************
	// Ring oscillator synchronizer
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ring_s1_q <= 1'b0;
			ring_s2_q <= 1'b0;
			ring_s3_q <= 1'b0;
		end else if (ce) begin
			ring_s1_q <= ring_osc;
			ring_s2_q <= ring_s1_q;
			ring_s3_q <= ring_s2_q;
		end
	end

	assign ring_tick = ring_s2_q & ~ring_s3_q;

	// ****************************************
	// Event decode
	// ****************************************
	assign mon_on = (state_q != pfs_pkg::PFS_PF_SLEEP) && (state_q != pfs_pkg::PFS_POR_HOLD)
		&& !((state_q == pfs_pkg::PFS_STOP) && mon_off_q);
	assign suppress = sup_bus_q & batt_present;
	assign pf_rst_ev = mon_on & below_reset & ~suppress;
	assign warn_cond = mon_on & below_warn & ~below_reset & ~suppress
		& ((state_q == pfs_pkg::PFS_RUN) || (state_q == pfs_pkg::PFS_STOP));
	assign warn_set = warn_cond && (warn_cnt_q == 16'(pfs_pkg::WARN_QUALIFY_CYC - 1));
	assign stop_req = wr && hit(addr, pfs_pkg::OFF_PWR) && wdata[pfs_pkg::PWR_STOP_BIT];
	assign ext_rst = ~ext_reset_n | wdt_reset;
	assign warm_done = (cyc_cnt_q >= 16'(pfs_pkg::XTAL_WARMUP_CYC - 1));
	assign timer_exp = (wake_q != 16'h0000) && (ring_cnt_q >= wake_q);
	assign wake_ev = ext_irq | warn_set | timer_exp;
	assign period_done = (ring_cnt_q >= period_ticks(intv_q));
	assign wake_exit_warn = (state_q == pfs_pkg::PFS_WAKE) && warm_done && below_warn
		&& !below_reset && !suppress;
	assign flag_clr = wr && hit(addr, pfs_pkg::OFF_CLK) && wdata[pfs_pkg::CLK_FLAG_BIT];

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		if (below_por) begin
			state_d = pfs_pkg::PFS_POR_HOLD;
		end else begin
			unique case (state_q)
				pfs_pkg::PFS_POR_HOLD: begin
					state_d = pfs_pkg::PFS_WARMUP;
				end
				pfs_pkg::PFS_WARMUP: begin
					if (warm_done) begin
						state_d = below_reset ? pfs_pkg::PFS_PF_SLEEP : pfs_pkg::PFS_RUN;
					end
				end
				pfs_pkg::PFS_RUN: begin
					if (ext_rst) begin
						state_d = pfs_pkg::PFS_EXT_RST;
					end else if (pf_rst_ev) begin
						state_d = pfs_pkg::PFS_PF_SLEEP;
					end else if (stop_req) begin
						state_d = pfs_pkg::PFS_STOP;
					end
				end
				pfs_pkg::PFS_STOP: begin
					if (ext_rst) begin
						state_d = pfs_pkg::PFS_EXT_RST;
					end else if (pf_rst_ev) begin
						state_d = pfs_pkg::PFS_PF_SLEEP;
					end else if (wake_ev) begin
						state_d = pfs_pkg::PFS_WAKE;
					end
				end
				pfs_pkg::PFS_WAKE: begin
					if (warm_done) begin
						state_d = below_reset && !suppress ? pfs_pkg::PFS_PF_SLEEP : pfs_pkg::PFS_RUN;
					end
				end
				pfs_pkg::PFS_PF_SLEEP: begin
					if (period_done) begin
						state_d = pfs_pkg::PFS_PF_SAMPLE;
					end
				end
				pfs_pkg::PFS_PF_SAMPLE: begin
					if (below_reset && monitor_en) begin
						state_d = pfs_pkg::PFS_PF_SLEEP;
					end else if (ring_tick && ring_cnt_q == 16'(pfs_pkg::SAMPLE_TICKS - 1)) begin
						state_d = pfs_pkg::PFS_PF_CONFIRM;
					end
				end
				pfs_pkg::PFS_PF_CONFIRM: begin
					if (below_reset && monitor_en) begin
						state_d = pfs_pkg::PFS_PF_SLEEP;
					end else if (ring_tick && ring_cnt_q == 16'(pfs_pkg::CONFIRM_TICKS - 1)) begin
						state_d = pfs_pkg::PFS_WARMUP;
					end
				end
				pfs_pkg::PFS_EXT_RST: begin
					if (!ext_rst && cyc_cnt_q >= 16'(pfs_pkg::EXT_RELEASE_CYC - 1)) begin
						state_d = pfs_pkg::PFS_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= pfs_pkg::PFS_POR_HOLD;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// Counters
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cyc_cnt_q <= 16'h0000;
		end else if (ce) begin
			if (state_d != state_q || (state_q == pfs_pkg::PFS_EXT_RST && ext_rst)) begin
				cyc_cnt_q <= 16'h0000;
			end else if (cyc_cnt_q != 16'hFFFF) begin
				cyc_cnt_q <= cyc_cnt_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ring_cnt_q <= 16'h0000;
		end else if (ce) begin
			if (state_d != state_q) begin
				ring_cnt_q <= 16'h0000;
			end else if (ring_tick && ring_cnt_q != 16'hFFFF) begin
				ring_cnt_q <= ring_cnt_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			warn_cnt_q <= 16'h0000;
		end else if (ce) begin
			if (!warn_cond) begin
				warn_cnt_q <= 16'h0000;
			end else if (!warn_set) begin
				warn_cnt_q <= warn_cnt_q + 16'h0001;
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lvl_q <= pfs_pkg::LVL_RST;
		end else if (ce) begin
			if (below_por) begin
				lvl_q <= pfs_pkg::LVL_RST;
			end else if (wr && hit(addr, pfs_pkg::OFF_PWR)) begin
				lvl_q <= wdata[pfs_pkg::PWR_LVL_LSB +: 2];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mon_off_q <= pfs_pkg::MON_OFF_RST;
			intv_q <= pfs_pkg::INTV_RST;
			wake_q <= pfs_pkg::WAKE_RST;
			ie_q <= 1'b0;
		end else if (ce && wr) begin
			if (hit(addr, pfs_pkg::OFF_PWR)) begin
				mon_off_q <= wdata[pfs_pkg::PWR_MON_OFF_BIT];
				intv_q <= wdata[pfs_pkg::PWR_INTV_LSB +: 2];
			end
			if (hit(addr, pfs_pkg::OFF_CLK)) begin
				ie_q <= wdata[pfs_pkg::CLK_IE_BIT];
			end
			if (hit(addr, pfs_pkg::OFF_WAKE)) begin
				wake_q <= wdata[15:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flag_q <= 1'b0;
		end else if (ce) begin
			if (warn_set || wake_exit_warn) begin
				flag_q <= 1'b1;
			end else if (flag_clr) begin
				flag_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= '0;
		end else if (ce) begin
			rdata <= '0;
			if (rd) begin
				unique case (addr)
					pfs_pkg::OFF_PWR: rdata <= {10'h000, 1'b0, intv_q, lvl_q, mon_off_q};
					pfs_pkg::OFF_CLK: rdata <= {14'h0000, flag_q, ie_q};
					pfs_pkg::OFF_WAKE: rdata <= wake_q;
					pfs_pkg::OFF_STAT: rdata <= {11'h000, sup_bus_q, 4'(state_q)};
					default: rdata <= '0;
				endcase
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sup_bus_q <= 1'b0;
			warn_level_sel <= pfs_pkg::LVL_RST;
			monitor_en <= 1'b0;
			regulator_en <= 1'b0;
			xtal_en <= 1'b0;
			cpu_clk_en <= 1'b0;
			cpu_reset_n <= 1'b0;
			start_rom <= 1'b0;
			stop_wake <= 1'b0;
			warn_irq <= 1'b0;
		end else if (ce) begin
			sup_bus_q <= bus_above_3v0 | bus_above_batt;
			warn_level_sel <= lvl_q;
			monitor_en <= mon_on;
			regulator_en <= state_q != pfs_pkg::PFS_STOP && state_q != pfs_pkg::PFS_PF_SLEEP
				&& state_q != pfs_pkg::PFS_PF_SAMPLE && state_q != pfs_pkg::PFS_PF_CONFIRM
				&& state_q != pfs_pkg::PFS_POR_HOLD;
			xtal_en <= state_q != pfs_pkg::PFS_STOP && state_q != pfs_pkg::PFS_PF_SLEEP
				&& state_q != pfs_pkg::PFS_PF_SAMPLE && state_q != pfs_pkg::PFS_PF_CONFIRM
				&& state_q != pfs_pkg::PFS_POR_HOLD;
			cpu_clk_en <= (state_q == pfs_pkg::PFS_RUN);
			cpu_reset_n <= (state_q == pfs_pkg::PFS_RUN) || (state_q == pfs_pkg::PFS_STOP)
				|| (state_q == pfs_pkg::PFS_WAKE);
			start_rom <= (state_q == pfs_pkg::PFS_WARMUP) && (state_d == pfs_pkg::PFS_RUN);
			stop_wake <= (state_q == pfs_pkg::PFS_STOP) && (state_d == pfs_pkg::PFS_WAKE);
			warn_irq <= flag_q & ie_q;
		end
	end

	assign supply_from_bus = sup_bus_q;

	// ****************************************
	// Assertions
	// ****************************************
	a_supply_select: assert property (@(posedge clk) disable iff (!rstn || !ce)
		1'b1 |=> sup_bus_q == $past(bus_above_3v0 || bus_above_batt))
		else $error("switched supply selection wrong");
	a_irq_follow: assert property (@(posedge clk) disable iff (!rstn || !ce)
		1'b1 |=> warn_irq == $past(flag_q && ie_q))
		else $error("warning irq does not follow flag and enable");
	a_bus_suppress: assert property (@(posedge clk) disable iff (!rstn || !ce)
		(suppress && !below_por && (state_q == pfs_pkg::PFS_RUN || state_q == pfs_pkg::PFS_STOP))
		|=> !$rose(flag_q) && state_q != pfs_pkg::PFS_PF_SLEEP)
		else $error("power-fail event while on bus with battery");
	a_stop_mon_off: assert property (@(posedge clk) disable iff (!rstn || !ce)
		(state_q == pfs_pkg::PFS_STOP && mon_off_q) |=> !monitor_en)
		else $error("monitor running in stop with monitor-off set");
	a_wake_mon_on: assert property (@(posedge clk) disable iff (!rstn || !ce)
		(state_q == pfs_pkg::PFS_WAKE) |=> monitor_en && !cpu_clk_en)
		else $error("monitor not enabled before stop exit");
	a_level_keep: assert property (@(posedge clk) disable iff (!rstn || !ce)
		(!(wr && hit(addr, pfs_pkg::OFF_PWR)) && !below_por) |=> $stable(lvl_q))
		else $error("level select changed without a write");
	a_por_hold: assert property (@(posedge clk) disable iff (!rstn || !ce)
		below_por ##1 1'b1 |=> !cpu_reset_n && !cpu_clk_en)
		else $error("cpu not held in reset below power-on level");
	a_ext_release: assert property (@(posedge clk) disable iff (!rstn || !ce)
		(state_q == pfs_pkg::PFS_EXT_RST && $fell(ext_rst) && !below_por) |-> ##[1:20] cpu_reset_n)
		else $error("cpu reset not released after external reset");
	a_stop_gates: assert property (@(posedge clk) disable iff (!rstn || !ce)
		(state_q == pfs_pkg::PFS_STOP) |=> !cpu_clk_en && !regulator_en && !xtal_en)
		else $error("stop mode did not gate clock and supplies");

endmodule : pfs_supervisor

/* bench/pfs_supply_model.sv */
`timescale 1ns/1ns
// ****
// Supply comparators and ring oscillator
// ****
module pfs_supply_model #(
	parameter int BUS_SEL_MV = 3000,
	parameter int RESET_MV = 1700,
	parameter int POR_MV = 1000,
	parameter int BATT_MV = 500,
	parameter int RING_HALF_NS = 1000
) (
	input wire logic clk,
	input wire logic [15:0] vdd_mv,
	input wire logic [15:0] vbus_mv,
	input wire logic [1:0] warn_level_sel,
	input wire logic monitor_en,
	output logic bus_above_3v0,
	output logic bus_above_batt,
	output logic batt_present,
	output logic below_warn,
	output logic below_reset,
	output logic below_por,
	output logic ring_osc
);
	int vsw;
	int warn_mv;
	logic junk_q = 1'b0;
	initial ring_osc = 1'b0;
	always #(RING_HALF_NS) ring_osc = ~ring_osc;
	always @(posedge clk) junk_q <= ~junk_q;
	always_comb begin
		bus_above_3v0 = int'(vbus_mv) > BUS_SEL_MV;
		bus_above_batt = vbus_mv > vdd_mv;
		batt_present = int'(vdd_mv) >= BATT_MV;
		vsw = (bus_above_3v0 || bus_above_batt) ? int'(vbus_mv) : int'(vdd_mv);
		case (warn_level_sel)
			2'h0: warn_mv = 1800;
			2'h1: warn_mv = 1900;
			2'h2: warn_mv = 2550;
			default: warn_mv = 2750;
		endcase
		// Comparators shut down give no trustworthy level
		below_warn = monitor_en ? (vsw < warn_mv) : junk_q;
		below_reset = monitor_en ? (vsw < RESET_MV) : ~junk_q;
		below_por = vsw < POR_MV;
	end
endmodule : pfs_supply_model

/* bench/pfs_supervisor_test.sv */
`timescale 1ns/1ns
module pfs_supervisor_test;
	localparam logic [15:0] V_OK = 16'h0CE4;
	localparam logic [15:0] V_WARN = 16'h0A28;
	localparam logic [15:0] V_LOW = 16'h05DC;
	localparam logic [15:0] V_BUS = 16'h1388;
	localparam logic [15:0] V_BATT = 16'h07D0;
	logic clk, rstn, ce, wr, rd, ext_irq, ext_reset_n, wdt_reset;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, vdd_mv, vbus_mv;
	logic bus_above_3v0, bus_above_batt, batt_present, below_warn, below_reset, below_por, ring_osc;
	logic supply_from_bus, monitor_en, regulator_en, xtal_en, cpu_clk_en, cpu_reset_n, start_rom, stop_wake, warn_irq;
	logic [1:0] warn_level_sel;
	int errors = 0;
	int n_compared = 0;
	int n;

	pfs_supervisor u_pfs_supervisor (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .bus_above_3v0(bus_above_3v0), .bus_above_batt(bus_above_batt),
		.batt_present(batt_present), .below_warn(below_warn), .below_reset(below_reset), .below_por(below_por),
		.ext_irq(ext_irq), .ext_reset_n(ext_reset_n), .wdt_reset(wdt_reset), .ring_osc(ring_osc),
		.supply_from_bus(supply_from_bus), .warn_level_sel(warn_level_sel), .monitor_en(monitor_en),
		.regulator_en(regulator_en), .xtal_en(xtal_en), .cpu_clk_en(cpu_clk_en), .cpu_reset_n(cpu_reset_n),
		.start_rom(start_rom), .stop_wake(stop_wake), .warn_irq(warn_irq));
	pfs_supply_model #(.RING_HALF_NS(200)) u_pfs_supply_model (.clk(clk), .vdd_mv(vdd_mv), .vbus_mv(vbus_mv),
		.warn_level_sel(warn_level_sel), .monitor_en(monitor_en), .bus_above_3v0(bus_above_3v0),
		.bus_above_batt(bus_above_batt), .batt_present(batt_present), .below_warn(below_warn),
		.below_reset(below_reset), .below_por(below_por), .ring_osc(ring_osc));

	// ****
	// Access tasks
	// ****
	function automatic logic [15:0] pwr(input logic off, input logic [1:0] lvl, input logic stop);
		return {10'h000, stop, 2'h0, lvl, off};
	endfunction : pwr
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("ERROR t=%0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata & m, e);
	endtask : rd_chk
	task automatic wait_hi(input int s, input int lim, output int k);
		k = 0;
		while (k < lim && !(s == 0 ? stop_wake === 1'b1 : s == 1 ? cpu_reset_n === 1'b1 :
			s == 2 ? start_rom === 1'b1 : cpu_clk_en === 1'b1)) begin
			@(negedge clk);
			k++;
		end
		chk(16'(k < lim), 16'h0001);
	endtask : wait_hi
	task automatic end_test(input string s);
		$display("test %s done, errors %0d", s, errors);
	endtask : end_test
	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	initial clk = 1'b0;
	always #50 clk = ~clk;
	initial begin
		#4000000;
		errors++;
		$display("ERROR t=%0t watchdog expired", $time);
		finish_test();
	end

	// ****
	// Tests
	// ****
	initial begin
		rstn = 1'b0; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 16'h0000;
		ext_irq = 1'b0; ext_reset_n = 1'b1; wdt_reset = 1'b0; vdd_mv = V_OK; vbus_mv = 16'h0000;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(pfs_pkg::OFF_PWR, 16'h0001, 16'hFFFF);
		rd_chk(pfs_pkg::OFF_CLK, 16'h0000, 16'hFFFF);
		rd_chk(pfs_pkg::OFF_WAKE, 16'h0000, 16'hFFFF);
		rd_chk(4'h7, 16'h0000, 16'hFFFF);
		wait_hi(1, 2100, n);
		rd_chk(pfs_pkg::OFF_STAT, 16'h0002, 16'h000F);
		end_test("reset");
		for (int i = 0; i < 4; i++) begin
			wr_reg(pfs_pkg::OFF_PWR, pwr(1'b1, 2'(i), 1'b0));
			repeat (2) @(negedge clk);
			chk({14'h0, warn_level_sel}, 16'(i));
		end
		wr_reg(pfs_pkg::OFF_CLK, 16'h0001);
		@(posedge clk) vdd_mv <= V_WARN;
		repeat (50) @(posedge clk);
		vdd_mv <= V_OK;
		rd_chk(pfs_pkg::OFF_CLK, 16'h0001, 16'h0003);
		@(posedge clk) vdd_mv <= V_WARN;
		repeat (110) @(posedge clk);
		rd_chk(pfs_pkg::OFF_CLK, 16'h0003, 16'h0003);
		chk({15'h0, warn_irq}, 16'h0001);
		@(posedge clk) vdd_mv <= V_OK;
		wr_reg(pfs_pkg::OFF_CLK, 16'h0003);
		rd_chk(pfs_pkg::OFF_CLK, 16'h0001, 16'h0003);
		end_test("warning");
		@(posedge clk) begin
			vbus_mv <= V_BUS;
			vdd_mv <= V_BATT;
		end
		repeat (4) @(negedge clk);
		chk({15'h0, supply_from_bus}, 16'h0001);
		@(posedge clk) vbus_mv <= V_WARN;
		repeat (200) @(posedge clk);
		rd_chk(pfs_pkg::OFF_CLK, 16'h0001, 16'h0003);
		chk({15'h0, supply_from_bus}, 16'h0001);
		@(posedge clk) begin
			vbus_mv <= 16'h0000;
			vdd_mv <= V_OK;
		end
		repeat (4) @(negedge clk);
		chk({15'h0, supply_from_bus}, 16'h0000);
		end_test("supply");
		wr_reg(pfs_pkg::OFF_PWR, pwr(1'b0, 2'h3, 1'b1));
		repeat (3) @(negedge clk);
		chk({12'h0, cpu_reset_n, cpu_clk_en, regulator_en, xtal_en}, 16'h0008);
		@(posedge clk) ext_irq <= 1'b1;
		wait_hi(0, 20, n);
		@(negedge clk);
		chk({13'h0, monitor_en, regulator_en, xtal_en}, 16'h0007);
		@(posedge clk) ext_irq <= 1'b0;
		wait_hi(3, 2100, n);
		end_test("stop");
		wr_reg(pfs_pkg::OFF_PWR, pwr(1'b1, 2'h3, 1'b1));
		@(posedge clk) vdd_mv <= V_WARN;
		repeat (200) @(posedge clk);
		rd_chk(pfs_pkg::OFF_CLK, 16'h0001, 16'h0003);
		chk({15'h0, monitor_en}, 16'h0000);
		@(posedge clk) ext_irq <= 1'b1;
		wait_hi(0, 20, n);
		@(posedge clk) ext_irq <= 1'b0;
		wait_hi(3, 2100, n);
		rd_chk(pfs_pkg::OFF_CLK, 16'h0003, 16'h0003);
		@(posedge clk) vdd_mv <= V_OK;
		wr_reg(pfs_pkg::OFF_CLK, 16'h0003);
		end_test("stop monitor off");
		wr_reg(pfs_pkg::OFF_WAKE, 16'h0010);
		wr_reg(pfs_pkg::OFF_PWR, pwr(1'b1, 2'h3, 1'b1));
		wait_hi(0, 70, n);
		chk(16'(n >= 60), 16'h0001);
		wait_hi(3, 2100, n);
		wr_reg(pfs_pkg::OFF_WAKE, 16'h0000);
		end_test("wake timer");
		wr_reg(pfs_pkg::OFF_CLK, 16'h0002);
		wr_reg(pfs_pkg::OFF_PWR, pwr(1'b1, 2'h2, 1'b1) | 16'h0008);
		@(posedge clk) vdd_mv <= V_LOW;
		repeat (50) @(negedge clk);
		chk({15'h0, cpu_reset_n}, 16'h0001);
		@(posedge clk) ext_irq <= 1'b1;
		wait_hi(0, 20, n);
		@(posedge clk) ext_irq <= 1'b0;
		repeat (2100) @(negedge clk);
		chk({12'h0, cpu_reset_n, cpu_clk_en, regulator_en, xtal_en}, 16'h0000);
		@(posedge clk) vdd_mv <= V_OK;
		wait_hi(2, 10500, n);
		chk(16'(n >= 8000), 16'h0001);
		wait_hi(1, 10, n);
		chk({14'h0, warn_level_sel}, 16'h0002);
		end_test("power-fail reset");
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) begin
				ext_reset_n <= (i != 0);
				wdt_reset <= (i != 0);
			end
			repeat (5) @(negedge clk);
			chk({12'h0, cpu_reset_n, monitor_en, regulator_en, xtal_en}, 16'h0007);
			@(posedge clk) begin
				ext_reset_n <= 1'b1;
				wdt_reset <= 1'b0;
			end
			wait_hi(1, 20, n);
			chk({14'h0, warn_level_sel}, 16'h0002);
		end
		end_test("external reset");
		@(posedge clk) vdd_mv <= 16'h0000;
		repeat (5) @(negedge clk);
		chk({15'h0, cpu_reset_n}, 16'h0000);
		@(posedge clk) vdd_mv <= V_OK;
		wait_hi(1, 2100, n);
		chk({14'h0, warn_level_sel}, 16'h0000);
		end_test("power-on");
		finish_test();
	end
endmodule : pfs_supervisor_test
